// [hw/rfc_pkg.sv]
// Package: register map, field positions and timing constants for the flags and century block
// How it works
// RL1 - Century register holds two BCD digits, each 0 to 9, range 0-99
// RL2 - Alarm flag sets when all unmasked alarm fields match; clears on flags read
// RL3 - Power-fail flag sets below switchover threshold; clears on flags read
// RL4 - Clearing write-freeze copies base time into counters after transfer interval; here baseLoad pulses the cycle after the clearing write
// RL5 - Host waits the transfer interval before starting a nonvolatile save
// RL6 - Each alarm field has a mask bit; one excludes the field from matching
// RL7 - Watchdog flag sets when counter reaches zero; clears on flags read
package rfc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RFC_FLAGS_IDX   = 8'h00;
  localparam logic [7:0] RFC_CENTURY_IDX = 8'h01;
  localparam logic [7:0] RFC_AMASK_IDX   = 8'h02;
  localparam logic [7:0] RFC_IRQST_IDX   = 8'h03;
  localparam logic [7:0] RFC_IRQEN_IDX   = 8'h04;
  localparam logic [7:0] RFC_XFER_IDX    = 8'h05;
  localparam logic [7:0] RFC_OSCCLR_IDX  = 8'h06;

  // ----------------------------------------------------------------
  // Flags register fields
  // ----------------------------------------------------------------
  localparam int RFC_WDOG_BIT    = 7;
  localparam int RFC_ALARM_BIT   = 6;
  localparam int RFC_PFAIL_BIT   = 5;
  localparam int RFC_OSCFAIL_BIT = 4;
  localparam int RFC_CAL_BIT  = 2;
  localparam int RFC_W_BIT    = 1;
  localparam int RFC_R_BIT    = 0;

  // Interrupt status bits
  localparam int RFC_IRQ_WIDTH = 4;
  localparam int RFC_IRQ_ALARM = 0;
  localparam int RFC_IRQ_PFAIL = 1;
  localparam int RFC_IRQ_WDOG  = 2;
  localparam int RFC_IRQ_XFER  = 3;

  localparam int RFC_NUM_FIELDS = 4;

  localparam logic [3:0] RFC_BCD_MAX  = 4'h9;
  localparam logic [3:0] RFC_BCD_ZERO = 4'h0;
  localparam logic [3:0] RFC_BCD_ONE  = 4'h1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RFC_CLK_MHZ       = 250;
  localparam int RFC_XFER_TIME_NS  = 1000;
  localparam int RFC_XFER_CYCLES   = (RFC_XFER_TIME_NS * RFC_CLK_MHZ + 999) / 1000;
  localparam int RFC_XFER_CNT_W    = 12;

  typedef struct packed {
    logic wdog;
    logic alarm;
    logic pfail;
    logic oscFail;
  } rfc_events_t;

  typedef struct packed {
    logic       cal;
    logic       wFreeze;
    logic       rFreeze;
    logic [7:0] century;
  } rfc_ctrl_t;

endpackage : rfc_pkg

// [hw/rfc_alarm_match.sv]
// Alarm comparison over masked BCD fields
`timescale 1ns/10ps
module rfc_alarm_match (
  input  wire logic [8*rfc_pkg::RFC_NUM_FIELDS-1:0] curTime,
  input  wire logic [8*rfc_pkg::RFC_NUM_FIELDS-1:0] alarmVal,
  input  wire logic [rfc_pkg::RFC_NUM_FIELDS-1:0]   alarmMask,
  output logic                                      match
);
  logic [rfc_pkg::RFC_NUM_FIELDS-1:0] fieldOk;

  genvar g;
  generate
    for (g = 0; g < rfc_pkg::RFC_NUM_FIELDS; g = g + 1) begin : gField
      // A set mask bit drops the field from the comparison
      assign fieldOk[g] = alarmMask[g] | (curTime[8*g +: 8] == alarmVal[8*g +: 8]); // RL6
    end
  endgenerate

  assign match = &fieldOk; // RL2
endmodule : rfc_alarm_match

// [hw/rfc_xfer_timer.sv]
// Base time transfer interval timer
`timescale 1ns/10ps
module rfc_xfer_timer (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  logic [rfc_pkg::RFC_XFER_CNT_W-1:0] cnt_r;
  localparam logic [rfc_pkg::RFC_XFER_CNT_W-1:0] CNT_INIT = rfc_pkg::RFC_XFER_CNT_W'(rfc_pkg::RFC_XFER_CYCLES);
  localparam logic [rfc_pkg::RFC_XFER_CNT_W-1:0] CNT_ONE  = rfc_pkg::RFC_XFER_CNT_W'(1);

  assign busy = (cnt_r != '0);

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= '0;
      done  <= 1'b0;
    end else begin
      done <= (cnt_r == CNT_ONE);
      if (start) begin
        cnt_r <= CNT_INIT; // RL4
      end else if (busy) begin
        cnt_r <= cnt_r - CNT_ONE;
      end
    end
  end
endmodule : rfc_xfer_timer

// [hw/rfc_flags_century.sv]
// Flags, century and interrupt logic with an APB slave
//
// The APB register port was decided locally.
`timescale 1ns/10ps
module rfc_flags_century (
  input  wire logic                                 mclk,
  input  wire logic                                 rst,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [7:0]                           paddr,
  input  wire logic [31:0]                          pwdata,
  output logic                                      pready,
  output logic                                      pslverr,
  output logic [31:0]                               prdata,
  input  wire logic                                 supplyLow,
  input  wire logic                                 oscFailIn,
  input  wire logic                                 wdogZero,
  input  wire logic [8*rfc_pkg::RFC_NUM_FIELDS-1:0] curTime,
  input  wire logic [8*rfc_pkg::RFC_NUM_FIELDS-1:0] alarmVal,
  input  wire logic                                 centuryCarry,
  output logic                                      calOutEn,
  output logic                                      readFreeze,
  output logic                                      writeFreeze,
  output logic                                      baseLoad,
  output logic                                      xferBusy,
  output logic                                      irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Supply and oscillator monitors are asynchronous, so they pass three stages
  logic [2:0] supSync_r;
  logic [2:0] ofSync_r;
  logic       supLevel_r;
  logic       ofLevel_r;
  logic       supPrev_r;
  logic       alarmPrev_r;
  logic       wdogPrev_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      supSync_r  <= 3'h0;
      ofSync_r   <= 3'h0;
      supLevel_r <= 1'b0;
      ofLevel_r  <= 1'b0;
    end else begin
      supSync_r <= {supSync_r[1:0], supplyLow};
      ofSync_r  <= {ofSync_r[1:0], oscFailIn};
      if (supSync_r[2] == supSync_r[1]) begin
        supLevel_r <= supSync_r[2];
      end
      if (ofSync_r[2] == ofSync_r[1]) begin
        ofLevel_r <= ofSync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Single-cycle access phase: pready is always high
  wire       apbAccess = psel & penable;
  wire       apbWrite  = apbAccess & pwrite;
  wire       apbRead   = apbAccess & ~pwrite;
  wire       addrAlign = (paddr[1:0] == 2'h0);
  wire [5:0] regIdx    = paddr[7:2];
  wire       selFlags  = addrAlign & (regIdx == rfc_pkg::RFC_FLAGS_IDX[5:0]);
  wire       selCent   = addrAlign & (regIdx == rfc_pkg::RFC_CENTURY_IDX[5:0]);
  wire       selMask   = addrAlign & (regIdx == rfc_pkg::RFC_AMASK_IDX[5:0]);
  wire       selIrqSt  = addrAlign & (regIdx == rfc_pkg::RFC_IRQST_IDX[5:0]);
  wire       selIrqEn  = addrAlign & (regIdx == rfc_pkg::RFC_IRQEN_IDX[5:0]);
  wire       selXfer   = addrAlign & (regIdx == rfc_pkg::RFC_XFER_IDX[5:0]);
  wire       selOscClr = addrAlign & (regIdx == rfc_pkg::RFC_OSCCLR_IDX[5:0]);
  wire       selAny    = selFlags | selCent | selMask | selIrqSt | selIrqEn | selXfer | selOscClr;

  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~selAny;

  // ----------------------------------------------------------------
  // Flag state
  // ----------------------------------------------------------------
  rfc_pkg::rfc_events_t flags_r;
  rfc_pkg::rfc_ctrl_t   ctrl_r;
  logic [rfc_pkg::RFC_NUM_FIELDS-1:0] alarmMask_r;
  logic [rfc_pkg::RFC_IRQ_WIDTH-1:0]  irqSt_r;
  logic [rfc_pkg::RFC_IRQ_WIDTH-1:0]  irqEn_r;

  wire alarmHit;

  rfc_alarm_match uMatch (
    .curTime   (curTime),
    .alarmVal  (alarmVal),
    .alarmMask (alarmMask_r),
    .match     (alarmHit)
  );

  wire flagsRead  = apbRead & selFlags;
  wire flagsWrite = apbWrite & selFlags;
  wire alarmEvt   = alarmHit & ~alarmPrev_r;            // RL2
  wire supEvt     = supLevel_r & ~supPrev_r;            // RL3
  wire wdogEvt    = wdogZero & ~wdogPrev_r;             // RL7
  wire wFall      = flagsWrite & ctrl_r.wFreeze & ~pwdata[rfc_pkg::RFC_W_BIT]; // RL4
  // Read data was taken at setup; a flag set after that stays for the next read
  wire alarmRdClr = flagsRead & prdata[rfc_pkg::RFC_ALARM_BIT]; // RL2
  wire pfailRdClr = flagsRead & prdata[rfc_pkg::RFC_PFAIL_BIT]; // RL3
  wire wdogRdClr  = flagsRead & prdata[rfc_pkg::RFC_WDOG_BIT];  // RL7

  // ----------------------------------------------------------------
  // Base time transfer
  // ----------------------------------------------------------------
  wire xferDone;

  rfc_xfer_timer uXfer (
    .mclk  (mclk),
    .rst   (rst),
    .start (wFall),
    .busy  (xferBusy),
    .done  (xferDone)
  );

  // ----------------------------------------------------------------
  // Century BCD arithmetic
  // ----------------------------------------------------------------
  wire [3:0] centLo     = ctrl_r.century[3:0];
  wire [3:0] centHi     = ctrl_r.century[7:4];
  wire       loWrap     = (centLo >= rfc_pkg::RFC_BCD_MAX);
  wire       hiWrap     = (centHi >= rfc_pkg::RFC_BCD_MAX);
  wire [3:0] loNxt      = loWrap ? rfc_pkg::RFC_BCD_ZERO : centLo + rfc_pkg::RFC_BCD_ONE;           // RL1
  wire [3:0] hiNxt      = loWrap ? (hiWrap ? rfc_pkg::RFC_BCD_ZERO : centHi + rfc_pkg::RFC_BCD_ONE)
                                 : centHi;                                                          // RL1
  wire [3:0] wrLo       = (pwdata[3:0] > rfc_pkg::RFC_BCD_MAX) ? rfc_pkg::RFC_BCD_MAX : pwdata[3:0]; // RL1
  wire [3:0] wrHi       = (pwdata[7:4] > rfc_pkg::RFC_BCD_MAX) ? rfc_pkg::RFC_BCD_MAX : pwdata[7:4]; // RL1
  // Writes land while frozen; the counter only steps when not frozen
  wire       centWrite  = apbWrite & selCent;
  wire       centStep   = centuryCarry & ~ctrl_r.wFreeze;

  // ----------------------------------------------------------------
  // Flags and control registers
  // ----------------------------------------------------------------
  // Set wins over a read-clear in the same cycle so no event is lost
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_r     <= '0;
      ctrl_r      <= '0;
      alarmMask_r <= '0;
      supPrev_r   <= 1'b0;
      alarmPrev_r <= 1'b0;
      wdogPrev_r  <= 1'b0;
    end else begin
      supPrev_r   <= supLevel_r;
      alarmPrev_r <= alarmHit;
      wdogPrev_r  <= wdogZero;
      flags_r.alarm   <= alarmEvt | (flags_r.alarm & ~alarmRdClr); // RL2
      flags_r.pfail   <= supEvt | (flags_r.pfail & ~pfailRdClr);   // RL3
      flags_r.wdog    <= wdogEvt | (flags_r.wdog & ~wdogRdClr);    // RL7
      // Oscillator flag survives reads; software clears it explicitly
      flags_r.oscFail <= ofLevel_r | (flags_r.oscFail & ~(apbWrite & selOscClr));
      if (flagsWrite) begin
        ctrl_r.cal     <= pwdata[rfc_pkg::RFC_CAL_BIT];
        ctrl_r.wFreeze <= pwdata[rfc_pkg::RFC_W_BIT];
        ctrl_r.rFreeze <= pwdata[rfc_pkg::RFC_R_BIT];
      end
      if (centWrite) begin
        ctrl_r.century <= {wrHi, wrLo}; // RL1
      end else if (centStep) begin
        ctrl_r.century <= {hiNxt, loNxt}; // RL1
      end
      if (apbWrite & selMask) begin
        alarmMask_r <= pwdata[rfc_pkg::RFC_NUM_FIELDS-1:0]; // RL6
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  wire [rfc_pkg::RFC_IRQ_WIDTH-1:0] irqSet    = {xferDone, wdogEvt, supEvt, alarmEvt};
  wire [rfc_pkg::RFC_IRQ_WIDTH-1:0] irqClr    = (apbWrite & selIrqSt) ? pwdata[rfc_pkg::RFC_IRQ_WIDTH-1:0] : '0;
  wire [rfc_pkg::RFC_IRQ_WIDTH-1:0] irqSt_nxt = irqSet | (irqSt_r & ~irqClr);
  wire [rfc_pkg::RFC_IRQ_WIDTH-1:0] irqEn_nxt = (apbWrite & selIrqEn) ? pwdata[rfc_pkg::RFC_IRQ_WIDTH-1:0] : irqEn_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqSt_r <= '0;
      irqEn_r <= '0;
      irq     <= 1'b0;
    end else begin
      irqSt_r <= irqSt_nxt;
      irqEn_r <= irqEn_nxt;
      // Both next values feed the pin, so a mask write acts together with the status
      irq     <= |(irqSt_nxt & irqEn_nxt);
    end
  end

  // ----------------------------------------------------------------
  // Read data and outputs
  // ----------------------------------------------------------------
  wire [7:0] flagsView = {flags_r.wdog, flags_r.alarm, flags_r.pfail, flags_r.oscFail, 1'b0,
                          ctrl_r.cal, ctrl_r.wFreeze, ctrl_r.rFreeze};
  wire [31:0] rdMux = selFlags  ? {24'h000000, flagsView} :
                      selCent   ? {24'h000000, ctrl_r.century} :
                      selMask   ? {28'h0000000, alarmMask_r} :
                      selIrqSt  ? {28'h0000000, irqSt_r} :
                      selIrqEn  ? {28'h0000000, irqEn_r} :
                      selXfer   ? {31'h00000000, xferBusy} : 32'h00000000;

  // Read data is registered during setup so it is valid in the access phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata     <= 32'h00000000;
      baseLoad   <= 1'b0;
    end else begin
      if (psel & ~penable & ~pwrite) begin
        prdata <= rdMux;
      end
      baseLoad <= wFall; // RL4
    end
  end

  assign calOutEn    = ctrl_r.cal;
  assign readFreeze  = ctrl_r.rFreeze;
  assign writeFreeze = ctrl_r.wFreeze;

endmodule : rfc_flags_century

// [verif/rfc_chk.sv]
// Assertion checker for the flags and century block
`timescale 1ns/10ps
module rfc_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        writeFreeze,
  input wire logic        calOutEn,
  input wire logic        baseLoad,
  input wire logic        xferBusy,
  input wire logic        irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [8:0] busyCnt_r;
  wire        acc    = psel && penable;
  wire        flagWr = acc && pwrite && paddr == 8'h00;
  // Counter avoids a 250-deep repetition that the tools would unroll
  always_ff @(posedge mclk) begin
    if (rst || !xferBusy) busyCnt_r <= 9'h000;
    else busyCnt_r <= busyCnt_r + 9'h001;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence freezeDrop; flagWr && !pwdata[1] && writeFreeze; endsequence
  sequence loadPulse; baseLoad ##1 !baseLoad; endsequence
  ready_zero_wait_a: assert property (acc |-> pready) else $error("pready low in access");
  base_load_a: assert property (freezeDrop |=> loadPulse) else $error("no load pulse");
  busy_start_a: assert property (freezeDrop |-> ##[1:2] xferBusy) else $error("no busy");
  busy_len_a: assert property ($fell(xferBusy) |-> busyCnt_r == 9'h0FA) else $error("busy len");
  ctrl_bits_a: assert property (flagWr |=> writeFreeze == $past(pwdata[1]) && calOutEn == $past(pwdata[2]))
    else $error("ctrl bits");
  century_bcd_a: assert property (acc && !pwrite && paddr == 8'h04 |-> prdata[3:0] <= 4'h9 && prdata[7:4] <= 4'h9
    && prdata[31:8] == 24'h0) else $error("century not BCD");
  bad_addr_a: assert property (acc && (paddr > 8'h18 || paddr[1:0] != 2'h0) |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access");
  irq_off_a: assert property (acc && pwrite && paddr == 8'h10 && pwdata[3:0] == 4'h0 |-> ##[1:2] !irq)
    else $error("irq not masked");
endmodule : rfc_chk

// [verif/rfc_apb_host.sv]
// APB host model issuing one register transfer at a time
`timescale 1ns/10ps
module rfc_apb_host (
  input  wire logic        mclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic [31:0]      rdWord,
  output logic             rdErr,
  output logic             rdStrobe
);
  initial begin
    {psel, penable, pwrite, rdErr, rdStrobe} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rdWord = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdWord <= prdata;
    rdErr <= pslverr;
    rdStrobe <= !w;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data is inverted so a stale value cannot pass for a real one
    pwdata <= ~d;
    @(posedge mclk);
    rdStrobe <= 1'b0;
  endtask : xfer
endmodule : rfc_apb_host

// [verif/rfc_tb.sv]
// Self-checking bench for the flags and century block
`timescale 1ns/10ps
module testbench;
  logic        mclk = 1'b0, rst = 1'b1, supplyLow = 1'b0, oscFailIn = 1'b0, wdogZero = 1'b0, centuryCarry = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, rdErr, rdStrobe;
  logic        calOutEn, readFreeze, writeFreeze, baseLoad, xferBusy, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdWord, v32, seed = 32'h00000063;
  logic [31:0] alarmVal = 32'h00000001, curTime = 32'h00000000;
  logic [31:0] expQ[$];
  int          fails = 0, checked = 0;
  always #2 mclk = ~mclk;
  rfc_flags_century DUT (
    .mclk         (mclk),
    .rst          (rst),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .prdata       (prdata),
    .supplyLow    (supplyLow),
    .oscFailIn    (oscFailIn),
    .wdogZero     (wdogZero),
    .curTime      (curTime),
    .alarmVal     (alarmVal),
    .centuryCarry (centuryCarry),
    .calOutEn     (calOutEn),
    .readFreeze   (readFreeze),
    .writeFreeze  (writeFreeze),
    .baseLoad     (baseLoad),
    .xferBusy     (xferBusy),
    .irq          (irq)
  );
  rfc_apb_host HOST (
    .mclk     (mclk),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .prdata   (prdata),
    .rdWord   (rdWord),
    .rdErr    (rdErr),
    .rdStrobe (rdStrobe)
  );
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [7:0] bcd();
    logic [31:0] r;
    r = rnd();
    return {r[7:4] % 4'hA, r[3:0] % 4'hA};
  endfunction : bcd
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    HOST.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    HOST.xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic idle(input int k);
    repeat (k) @(posedge mclk);
  endtask : idle
  task automatic cen(input logic [7:0] w, input logic c, input logic [7:0] e);
    wr(8'h04, {24'h0, w});
    if (c) begin
      @(posedge mclk) centuryCarry <= 1'b1;
      @(posedge mclk) centuryCarry <= 1'b0;
    end
    rd(8'h04, {24'h0, e});
  endtask : cen
  always @(posedge mclk) begin
    if (rdStrobe === 1'b1) check(rdWord, expQ.pop_front());
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    for (int i = 0; i < 5; i++) begin
      v32[7:0] = bcd();
      cen(v32[7:0], 1'b0, v32[7:0]);
    end
    cen(8'hAB, 1'b0, 8'h99);
    cen(8'h09, 1'b1, 8'h10);
    cen(8'h99, 1'b1, 8'h00);
    v32 = {bcd(), bcd(), bcd(), bcd()};
    alarmVal <= v32;
    curTime <= v32 ^ 32'h00000001;
    wr(8'h10, 32'h1);
    idle(8);
    check({31'h0, irq}, 32'h0);
    rd(8'h00, 32'h0);
    wr(8'h08, 32'h1);
    idle(8);
    check({31'h0, irq}, 32'h1);
    rd(8'h00, 32'h40);
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h1);
    wr(8'h0C, 32'h1);
    idle(3);
    check({31'h0, irq}, 32'h0);
    supplyLow <= 1'b1;
    idle(8);
    check({31'h0, irq}, 32'h0);
    rd(8'h00, 32'h20);
    rd(8'h00, 32'h0);
    wr(8'h10, 32'h2);
    idle(3);
    check({31'h0, irq}, 32'h1);
    supplyLow <= 1'b0;
    wdogZero <= 1'b1;
    idle(6);
    wdogZero <= 1'b0;
    rd(8'h00, 32'h80);
    rd(8'h00, 32'h0);
    wr(8'h0C, 32'hF);
    wr(8'h10, 32'h0);
    oscFailIn <= 1'b1;
    idle(8);
    rd(8'h00, 32'h10);
    rd(8'h00, 32'h10);
    oscFailIn <= 1'b0;
    idle(8);
    wr(8'h18, 32'h0);
    rd(8'h00, 32'h0);
    wr(8'h00, 32'h7);
    check({29'h0, calOutEn, readFreeze, writeFreeze}, 32'h7);
    cen(8'h21, 1'b1, 8'h21);
    wr(8'h10, 32'h8);
    wr(8'h00, 32'h0);
    idle(2);
    check({31'h0, xferBusy}, 32'h1);
    repeat (300) if (xferBusy === 1'b1) @(posedge mclk);
    idle(2);
    check({30'h0, xferBusy, irq}, 32'h1);
    rd(8'h0C, 32'h8);
    rd(8'h1C, 32'h0);
    check({31'h0, rdErr}, 32'h1);
    rd(8'h05, 32'h0);
    idle(4);
    finish_test();
  end
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule : testbench
bind rfc_flags_century rfc_chk CHK (
  .mclk        (mclk),
  .rst         (rst),
  .psel        (psel),
  .penable     (penable),
  .pwrite      (pwrite),
  .paddr       (paddr),
  .pwdata      (pwdata),
  .pready      (pready),
  .pslverr     (pslverr),
  .prdata      (prdata),
  .writeFreeze (writeFreeze),
  .calOutEn    (calOutEn),
  .baseLoad    (baseLoad),
  .xferBusy    (xferBusy),
  .irq         (irq)
);
